// ==== include/flash_poll_map.svh ====
// Offsets, field positions and timing counts of the flash status poller.
// Assumes a 250 MHz hclk and a 16-bit asynchronous NOR flash bus.
`ifndef FLASH_POLL_MAP_SVH
`define FLASH_POLL_MAP_SVH

// Flash bus widths
`define FP_ADDR_W 22
`define FP_DATA_W 16

// Clock period and strobe timing
`define FP_CLK_NS 4
`define FP_T_RD_NS 70
`define FP_RD_CYC ((`FP_T_RD_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_T_WP_NS 35
`define FP_WP_CYC ((`FP_T_WP_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)

// Register offsets (haddr[7:0])
`define FP_OFF_CTRL 8'h00
`define FP_OFF_ADDR 8'h04
`define FP_OFF_EXP 8'h08
`define FP_OFF_STATUS 8'h0C
`define FP_OFF_DATA 8'h10

// CTRL fields
`define FP_CTRL_START 0
`define FP_CTRL_ABORT 1
`define FP_CTRL_MODE 2

// STATUS fields
`define FP_ST_BUSY 0
`define FP_ST_DONE 1
`define FP_ST_FAIL 2
`define FP_ST_READY 3
`define FP_ST_TERR 4
`define FP_ST_TOG2 5

// Status bit positions on the data bus
`define FP_BIT_POLL 7
`define FP_BIT_TOG1 6
`define FP_BIT_TERR 5
`define FP_BIT_TOG2 2

// Reset command data
`define FP_RESET_CMD 16'h00F0

`endif

// ==== include/flash_poll_pkg.sv ====
// Types shared by the flash status poller modules.
// Assumes flash_poll_map.svh is on the include path.
`include "flash_poll_map.svh"

package flash_poll_pkg;

  // Polling procedure chosen by software
  typedef enum logic [1:0] {MODE_DATA, MODE_TOGGLE, MODE_RESET, MODE_SPARE} poll_mode_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RD_A, ST_RD_B, ST_RD_DATA, ST_RST_WR} poll_state_t;

  typedef enum logic [1:0] {CY_IDLE, CY_STROBE, CY_GAP} cyc_state_t;

  // Flash pins driven by the host
  typedef struct packed {
    logic [`FP_ADDR_W-1:0] addr;
    logic [`FP_DATA_W-1:0] dq_out;
    logic                  dq_oe;
    logic                  ce_n;
    logic                  oe_n;
    logic                  we_n;
  } flash_pins_t;

  typedef struct packed {
    cyc_state_t            st;
    logic [7:0]            cnt;
    logic                  wr;
    flash_pins_t           pins;
    logic [`FP_DATA_W-1:0] rdata;
    logic                  done;
  } cyc_t;

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_off;
    logic [31:0] hrdata;
  } port_t;

  typedef struct packed {
    poll_state_t           st;
    poll_mode_t            mode;
    logic [`FP_ADDR_W-1:0] addr;
    logic [`FP_DATA_W-1:0] exp_data;
    logic [`FP_DATA_W-1:0] last;
    logic [`FP_DATA_W-1:0] data;
    logic                  busy;
    logic                  done;
    logic                  fail;
    logic                  recheck;
    logic                  terr_seen;
    logic                  tog2_seen;
    logic                  abort;
    logic                  issue;
  } poll_t;

endpackage

// ==== verilog/flash_bus_cycle.sv ====
// One asynchronous flash read or write cycle, strobes timed in hclk cycles.
// Assumes dq_in is synchronous to hclk and one request at a time.
`timescale 1ns/10ps
`default_nettype none
`include "flash_poll_map.svh"

module flash_bus_cycle
  import flash_poll_pkg::*;
#(
  parameter int RD_CYC = `FP_RD_CYC,
  parameter int WP_CYC = `FP_WP_CYC
)
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Request
  input  wire logic                  req,
  input  wire logic                  req_wr,
  input  wire logic [`FP_ADDR_W-1:0] req_addr,
  input  wire logic [`FP_DATA_W-1:0] req_wdata,
  output logic                       done,
  output logic [`FP_DATA_W-1:0]      rdata,
  // Flash pins
  input  wire logic [`FP_DATA_W-1:0] dq_in,
  output flash_pins_t                pins
);

  cyc_t q;
  cyc_t n;

  // Each cycle raises every strobe at its end, so each read is a new cycle
  always_comb
  begin
    n      = q;
    n.done = 1'b0;
    unique case (q.st)
      CY_IDLE:
      begin
        if (req)
        begin
          n.pins.addr = req_addr;
          n.pins.ce_n = 1'b0;
          n.wr        = req_wr;
          n.st        = CY_STROBE;
          if (req_wr)
          begin
            n.pins.we_n   = 1'b0;
            n.pins.dq_oe  = 1'b1;
            n.pins.dq_out = req_wdata;
            n.cnt         = 8'(WP_CYC - 1);
          end
          else
          begin
            n.pins.oe_n = 1'b0;
            n.cnt       = 8'(RD_CYC - 1);
          end
        end
      end
      CY_STROBE:
      begin
        if (q.cnt == 8'h00)
        begin
          if (!q.wr)
            n.rdata = dq_in;
          n.pins.ce_n = 1'b1;
          n.pins.oe_n = 1'b1;
          n.pins.we_n = 1'b1;
          n.done      = 1'b1;
          n.st        = CY_GAP;
        end
        else
          n.cnt = q.cnt - 8'h01;
      end
      CY_GAP:
      begin
        // Data held one cycle past the write strobe rising edge
        n.pins.dq_oe = 1'b0;
        n.st         = CY_IDLE;
      end
      default:
        n.st = CY_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '{st: CY_IDLE, cnt: 8'h00, wr: 1'b0,
             pins: '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1},
             rdata: '0, done: 1'b0};
    end
    else
      q <= n;
  end

  assign done  = q.done;
  assign rdata = q.rdata;
  assign pins  = q.pins;

endmodule // flash_bus_cycle

`default_nettype wire

// ==== verilog/ahb_lite_port.sv ====
// AHB-Lite slave front end: zero wait states, word transfers, OKAY only.
// Assumes the owner supplies the read word for rd_off combinationally.
`timescale 1ns/10ps
`default_nettype none

module ahb_lite_port
  import flash_poll_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Register side
  output logic [7:0]       rd_off,
  input  wire logic [31:0] rd_word,
  output logic             wr_stb,
  output logic [7:0]       wr_off,
  output logic [31:0]      wr_data
);

  port_t q;
  port_t n;
  logic  accept;

  // Only whole-word transfers are honoured; others complete with no effect
  assign accept = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_comb
  begin
    n         = q;
    n.wr_pend = accept && hwrite;
    n.wr_off  = haddr[7:0];
    // Read data captured at address phase, so it stands in the data phase
    n.hrdata  = (accept && !hwrite) ? rd_word : 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '{wr_pend: 1'b0, wr_off: 8'h00, hrdata: 32'h0000_0000};
    else
      q <= n;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.hrdata;
  assign rd_off    = haddr[7:0];
  assign wr_stb    = q.wr_pend;
  assign wr_off    = q.wr_off;
  assign wr_data   = hwdata;

endmodule // ahb_lite_port

`default_nettype wire

// ==== verilog/flash_status_poller.sv ====
// Host-side poller of a NOR flash's write status over its asynchronous bus.
// Assumes an AHB-Lite master for software and flash inputs synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
`include "flash_poll_map.svh"

// Behaviour
// - Host polls data polling bit at the programmed address.
// - Host polls erase status at an address inside a selected sector.
// - Host takes array data only from the read after completion is seen.
// - Host reads twice and compares toggle bit; equal means done.
// - Still toggling with timeout error set: recheck, then reset on failure.
// - Polling that is broken off restarts from the first double read.
// - Reset command is one write of F0 to any address.
// - Status reads address the busy bank; other banks give array data.
module flash_status_poller
  import flash_poll_pkg::*;
#(
  parameter int RD_CYC = `FP_RD_CYC,
  parameter int WP_CYC = `FP_WP_CYC
)
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite register port
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Flash bus
  output flash_pins_t                flash_pins,
  input  wire logic [`FP_DATA_W-1:0] dq_in,
  input  wire logic                  ready_busy_n
);

  poll_t                 q;
  poll_t                 n;
  logic [7:0]            rd_off;
  logic [31:0]           rd_word;
  logic                  wr_stb;
  logic [7:0]            wr_off;
  logic [31:0]           wr_data;
  logic                  cyc_done;
  logic [`FP_DATA_W-1:0] cyc_rdata;
  logic                  cyc_wr;
  logic                  start_go;
  logic                  poll_hit;
  logic                  tog_same;

  // Software register port
  ahb_lite_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_off    (rd_off),
    .rd_word   (rd_word),
    .wr_stb    (wr_stb),
    .wr_off    (wr_off),
    .wr_data   (wr_data)
  );

  // Only the reset command is a write; all polls are reads
  assign cyc_wr = (q.st == ST_RST_WR);

  // Flash cycle engine; every poll uses the address held in q.addr
  flash_bus_cycle #(
    .RD_CYC (RD_CYC),
    .WP_CYC (WP_CYC)
  ) u_cycle (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .req       (q.issue),
    .req_wr    (cyc_wr),
    .req_addr  (q.addr),
    .req_wdata (`FP_RESET_CMD),
    .done      (cyc_done),
    .rdata     (cyc_rdata),
    .dq_in     (dq_in),
    .pins      (flash_pins)
  );

  // Register read mux; unmapped offsets read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (rd_off)
      `FP_OFF_CTRL:   rd_word[`FP_CTRL_MODE +: 2] = q.mode;
      `FP_OFF_ADDR:   rd_word[`FP_ADDR_W-1:0] = q.addr;
      `FP_OFF_EXP:    rd_word[`FP_DATA_W-1:0] = q.exp_data;
      `FP_OFF_DATA:   rd_word[`FP_DATA_W-1:0] = q.data;
      `FP_OFF_STATUS:
      begin
        rd_word[`FP_ST_BUSY]  = q.busy;
        rd_word[`FP_ST_DONE]  = q.done;
        rd_word[`FP_ST_FAIL]  = q.fail;
        rd_word[`FP_ST_READY] = ready_busy_n;
        rd_word[`FP_ST_TERR]  = q.terr_seen;
        rd_word[`FP_ST_TOG2]  = q.tog2_seen;
      end
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  // Start decode and decisions on a finished read
  assign start_go = wr_stb && (wr_off == `FP_OFF_CTRL) && wr_data[`FP_CTRL_START] && !q.busy;
  assign poll_hit = (cyc_rdata[`FP_BIT_POLL] == q.exp_data[`FP_BIT_POLL]);
  assign tog_same = (cyc_rdata[`FP_BIT_TOG1] == q.last[`FP_BIT_TOG1]);

  // Polling procedure and register writes
  always_comb
  begin
    n       = q;
    n.issue = 1'b0;
    // Setup registers are frozen while a poll runs, so the address stays put
    if (wr_stb && !q.busy && (wr_off == `FP_OFF_ADDR))
      n.addr = wr_data[`FP_ADDR_W-1:0];
    if (wr_stb && !q.busy && (wr_off == `FP_OFF_EXP))
      n.exp_data = wr_data[`FP_DATA_W-1:0];
    if (wr_stb && q.busy && (wr_off == `FP_OFF_CTRL) && wr_data[`FP_CTRL_ABORT])
      n.abort = 1'b1;
    if (start_go)
    begin
      // Every start begins with a fresh first read, or in reset mode with the reset write
      n.mode      = poll_mode_t'(wr_data[`FP_CTRL_MODE +: 2]);
      n.busy      = 1'b1;
      n.done      = 1'b0;
      n.fail      = 1'b0;
      n.recheck   = 1'b0;
      n.terr_seen = 1'b0;
      n.tog2_seen = 1'b0;
      n.abort     = 1'b0;
      n.issue     = 1'b1;
      n.st        = (n.mode == MODE_RESET) ? ST_RST_WR : ST_RD_A;
    end
    else if (cyc_done)
    begin
      unique case (q.st)
        ST_RD_A:
        begin
          n.issue = 1'b1;
          if (q.abort)
          begin
            // Broken off; a later start runs the whole procedure again
            n.st    = ST_IDLE;
            n.busy  = 1'b0;
            n.issue = 1'b0;
          end
          else if (q.mode == MODE_TOGGLE)
          begin
            n.last = cyc_rdata;
            n.st   = ST_RD_B;
          end
          else if (poll_hit)
            n.st = ST_RD_DATA;
          else if (q.recheck)
            n.st = ST_RST_WR;
          else if (cyc_rdata[`FP_BIT_TERR])
          begin
            // Polling bit may flip together with the error bit: read once more
            n.recheck   = 1'b1;
            n.terr_seen = 1'b1;
          end
        end
        ST_RD_B:
        begin
          n.issue     = 1'b1;
          n.tog2_seen = cyc_rdata[`FP_BIT_TOG2] ^ q.last[`FP_BIT_TOG2];
          n.st        = ST_RD_A;
          if (q.abort)
          begin
            n.st    = ST_IDLE;
            n.busy  = 1'b0;
            n.issue = 1'b0;
          end
          else if (tog_same)
            n.st = ST_RD_DATA;
          else if (q.recheck)
            n.st = ST_RST_WR;
          else if (cyc_rdata[`FP_BIT_TERR])
          begin
            n.recheck   = 1'b1;
            n.terr_seen = 1'b1;
          end
        end
        ST_RD_DATA:
        begin
          // Array data is taken from the read after completion was seen
          n.data = cyc_rdata;
          n.done = 1'b1;
          n.busy = 1'b0;
          n.st   = ST_IDLE;
        end
        ST_RST_WR:
        begin
          n.fail = (q.mode != MODE_RESET);
          n.done = (q.mode == MODE_RESET);
          n.busy = 1'b0;
          n.st   = ST_IDLE;
        end
        ST_IDLE:
          n.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '{st: ST_IDLE, mode: MODE_DATA, addr: '0, exp_data: '0, last: '0, data: '0,
             busy: 1'b0, done: 1'b0, fail: 1'b0, recheck: 1'b0, terr_seen: 1'b0,
             tog2_seen: 1'b0, abort: 1'b0, issue: 1'b0};
    end
    else
      q <= n;
  end

  // Checks on the polling procedure
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_same_pair;
    q.st == ST_RD_B && cyc_done && tog_same && !q.abort;
  endsequence

  sequence s_diff_first;
    q.st == ST_RD_B && cyc_done && !tog_same && !q.abort && !q.recheck;
  endsequence

  sequence s_data_read;
    q.st == ST_RD_DATA ##[1:40] $rose(q.done);
  endsequence

  prog_addr_a: assert property (
    !flash_pins.oe_n && q.mode == MODE_DATA |-> flash_pins.addr == q.addr)
    else $error("data poll read not at the programmed address");

  erase_addr_a: assert property (
    $fell(flash_pins.oe_n) && q.exp_data[`FP_BIT_POLL] |=> $stable(flash_pins.addr) [*4])
    else $error("erase poll address moved during a read");

  bank_addr_a: assert property (
    !flash_pins.ce_n && q.mode == MODE_TOGGLE |-> flash_pins.addr == q.addr)
    else $error("toggle poll read left the busy bank address");

  pair_done_a: assert property (
    s_same_pair |=> s_data_read)
    else $error("equal toggle pair did not end in a data read");

  data_late_a: assert property (
    $rose(q.done) && q.mode != MODE_RESET |-> $past(q.st) == ST_RD_DATA)
    else $error("done raised without a following data read");

  fail_reset_a: assert property (
    $rose(q.fail) |-> $past(q.st) == ST_RST_WR && $past(q.recheck))
    else $error("failure reported without recheck and reset command");

  diff_retry_a: assert property (
    s_diff_first |=> q.st == ST_RD_A && q.busy)
    else $error("first toggling pair did not restart the double read");

  restart_a: assert property (
    start_go |=> !q.recheck && q.issue && (q.st == ST_RD_A || q.st == ST_RST_WR))
    else $error("start did not begin from the first read");

  reset_cmd_a: assert property (
    !flash_pins.we_n |-> flash_pins.dq_oe && flash_pins.dq_out == `FP_RESET_CMD)
    else $error("write cycle is not the reset command");

endmodule // flash_status_poller

`default_nettype wire

// ==== verification/flash_bank_model.sv ====
// Behavioural flash bank that answers the poller's status and array reads.
// Assumes registered host strobes; the bench adds the ready/busy pull-up.
`timescale 1ns/10ps
`default_nettype none
`include "flash_poll_map.svh"

module flash_bank_model
  import flash_poll_pkg::*;
(
  // Host strobes
  input  wire logic                  hclk,
  input  wire flash_pins_t           pins,
  // Operation loaded by the bench
  input  wire logic                  ld,
  input  wire logic [1:0]            ld_op,
  input  wire logic [7:0]            ld_reads,
  input  wire logic                  ld_terr,
  input  wire logic                  ld_prot,
  input  wire logic [`FP_ADDR_W-1:0] ld_addr,
  input  wire logic [`FP_DATA_W-1:0] ld_datum,
  input  wire logic [`FP_DATA_W-1:0] ld_old,
  // Flash outputs
  output logic [`FP_DATA_W-1:0]      dq,
  output logic                       rb_low,
  output logic [7:0]                 rst_cnt
);
  logic                  busy_q = 1'b0;
  logic                  susp_q = 1'b0;
  logic                  prog_q, terr_q, prot_q, fresh_q, rd_q, wr_q, tog1_q, tog2_q;
  logic [7:0]            left_q;
  logic [`FP_ADDR_W-1:0] addr_q;
  logic [`FP_DATA_W-1:0] datum_q, old_q;
  logic [`FP_DATA_W-1:0] word_q = 16'h0000;
  logic                  rd, wr;

  // Strobe decode
  assign rd = ~pins.ce_n & ~pins.oe_n;
  assign wr = ~pins.ce_n & ~pins.we_n;
  // Off the bus, show the inverse so a stale sample cannot pass
  assign dq = rd ? word_q : ~word_q;
  // Open drain: low only while an algorithm actually runs
  assign rb_low = busy_q & ~susp_q;

  // Reads latch a word when both strobes fall
  always @(posedge hclk)
  begin
    rd_q <= rd;
    wr_q <= wr;
    if (ld)
    begin
      busy_q  <= (ld_op != 2'd0);
      susp_q  <= (ld_op == 2'd3);
      prog_q  <= (ld_op == 2'd1);
      left_q  <= ld_reads;
      terr_q  <= ld_terr;
      prot_q  <= ld_prot;
      addr_q  <= ld_addr;
      datum_q <= ld_datum;
      old_q   <= ld_old;
      fresh_q <= 1'b1;
      tog1_q  <= 1'b0;
      tog2_q  <= 1'b0;
      rst_cnt <= 8'h00;
    end
    else if (rd && !rd_q && busy_q && pins.addr == addr_q)
    begin
      word_q <= {8'h00, prog_q ? ~datum_q[7] : susp_q, tog1_q, terr_q, 2'b00, tog2_q,
                 2'b00};
      tog1_q <= tog1_q ^ ~susp_q;
      tog2_q <= tog2_q ^ ~prog_q;
      left_q <= left_q - 8'd1;
      // Protected targets just run the count out and change nothing
      if (left_q == 8'd1 && !susp_q && !terr_q)
        busy_q <= 1'b0;
    end
    else if (rd && !rd_q)
    begin
      // Upper bits may still be settling on the first array read
      word_q  <= (prot_q ? old_q : datum_q) ^ (fresh_q ? 16'hFF00 : 16'h0000);
      fresh_q <= 1'b0;
    end
    else if (!wr && wr_q && pins.dq_out[7:0] == 8'hF0)
    begin
      rst_cnt <= rst_cnt + 8'd1;
      busy_q  <= susp_q;
    end
  end
endmodule // flash_bank_model

`default_nettype wire

// ==== verification/flash_write_status_reporting_tb.sv ====
// Self-checking bench of the flash status poller against a flash bank model.
// Assumes the poller package, map header and bank model compile first.
`timescale 1ns/10ps
`default_nettype none
`include "flash_poll_map.svh"

module flash_write_status_reporting_tb
  import flash_poll_pkg::*;
;
  typedef struct packed {
    logic [1:0]  mode, op;
    logic [7:0]  reads;
    logic        terr, prot, rst;
    logic [15:0] datum, old, exp, dmask;
    logic [5:0]  st;
  } row_t;

  // Mode, op, reads, timeout, protected, reset write, data, old, expect, mask, status
  localparam row_t rows [0:8] = '{
    '{2'd0, 2'd1, 8'd3, 1'b0, 1'b0, 1'b0, 16'h5A3C, 16'h0000, 16'h5A3C, 16'hFFFF, 6'h0A},
    '{2'd0, 2'd2, 8'd2, 1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0000, 16'h0080, 16'hFFFF, 6'h0A},
    '{2'd1, 2'd1, 8'd4, 1'b0, 1'b0, 1'b0, 16'h1234, 16'h0000, 16'h0000, 16'hFFFF, 6'h0A},
    '{2'd1, 2'd2, 8'd8, 1'b1, 1'b0, 1'b1, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 6'h3C},
    '{2'd0, 2'd1, 8'd8, 1'b1, 1'b0, 1'b1, 16'h1280, 16'h0000, 16'h1280, 16'h0000, 6'h1C},
    '{2'd1, 2'd1, 8'd2, 1'b0, 1'b1, 1'b0, 16'h00FF, 16'hABCD, 16'h0000, 16'hFFFF, 6'h0A},
    '{2'd1, 2'd3, 8'd1, 1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 6'h2A},
    '{2'd2, 2'd0, 8'd1, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 6'h0A},
    '{2'd3, 2'd1, 8'd1, 1'b0, 1'b0, 1'b0, 16'h0080, 16'h0000, 16'h0080, 16'hFFFF, 6'h0A}};

  // Bus, flash and model wires
  logic                  hclk = 1'b0;
  logic                  hresetn, hsel, hwrite, hreadyout, hresp, ready_busy_n;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr, hwdata, hrdata;
  flash_pins_t           flash_pins;
  logic [`FP_DATA_W-1:0] dq_in, mdq, m_datum, m_old;
  logic                  rb_low, ld, m_terr, m_prot;
  logic [1:0]            m_op;
  logic [7:0]            m_reads, rst_cnt;
  logic [`FP_ADDR_W-1:0] m_addr = 22'h01_2340;
  int                    n_errors = 0;
  int                    cmp_count = 0;

  // Clock and wire resolution; ready/busy has a pull-up
  always #2 hclk = ~hclk;
  assign dq_in = flash_pins.dq_oe ? flash_pins.dq_out : mdq;
  assign ready_busy_n = rb_low ? 1'b0 : 1'b1;

  flash_status_poller #(.RD_CYC(5), .WP_CYC(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_pins(flash_pins),
    .dq_in(dq_in), .ready_busy_n(ready_busy_n));

  flash_bank_model bank (
    .hclk(hclk), .pins(flash_pins), .ld(ld), .ld_op(m_op), .ld_reads(m_reads),
    .ld_terr(m_terr), .ld_prot(m_prot), .ld_addr(m_addr), .ld_datum(m_datum),
    .ld_old(m_old), .dq(mdq), .rb_low(rb_low), .rst_cnt(rst_cnt));

  task automatic summarize();
    $display("Checks %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single word transfer; read data taken at the edge that ends the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    // Read data taken at the edge that ends the data phase
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(nm, e, x & m);
    chk("okay resp", 32'h0000_0000, {31'h0, hresp});
  endtask

  task automatic load(input logic [1:0] op, input logic [7:0] n, input logic t,
                      input logic p, input logic [15:0] d, input logic [15:0] o);
    @(posedge hclk);
    ld      <= 1'b1;
    m_op    <= op;
    m_reads <= n;
    m_terr  <= t;
    m_prot  <= p;
    m_datum <= d;
    m_old   <= o;
    @(posedge hclk);
    ld <= 1'b0;
  endtask

  // Bounded wait for the busy flag to drop
  task automatic wait_idle();
    logic [31:0] s;
    int          i;
    s = 32'h0000_0001;
    for (i = 0; i < 2000 && s[0] !== 1'b0; i++)
      ahb(1'b0, `FP_OFF_STATUS, 32'h0000_0000, s);
    chk("busy wait", 32'h0000_0000, {31'h0, s[0]});
  endtask

  // Watchdog: far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    n_errors++;
    $display("ERROR watchdog expected end seen timeout");
    summarize();
  end

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'b00;
    haddr   = 32'h0000_0000;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0000_0000;
    ld      = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      load(rows[i].op, rows[i].reads, rows[i].terr, rows[i].prot, rows[i].datum, rows[i].old);
      wr(`FP_OFF_ADDR, {10'h000, m_addr});
      wr(`FP_OFF_EXP, {16'h0000, rows[i].exp});
      wr(`FP_OFF_CTRL, {28'h000_0000, rows[i].mode, 2'b01});
      wait_idle();
      rdc("status", `FP_OFF_STATUS, 32'h0000_003F, {26'h0, rows[i].st});
      rdc("data", `FP_OFF_DATA, {16'h0000, rows[i].dmask},
          {16'h0000, (rows[i].prot ? rows[i].old : rows[i].datum) & rows[i].dmask});
      chk("reset writes", {31'h0, rows[i].rst}, {24'h00_0000, rst_cnt});
      rdc("ctrl mode", `FP_OFF_CTRL, 32'h0000_000F, {28'h0, rows[i].mode, 2'b00});
    end
    // Busy window: address held off, ready/busy low, then abort
    load(2'd1, 8'd200, 1'b0, 1'b0, 16'h1111, 16'h0000);
    // Expected bit 7 of 0 never matches the inverted status, so the poll stays busy
    wr(`FP_OFF_EXP, 32'h0000_0000);
    wr(`FP_OFF_CTRL, 32'h0000_0001);
    rdc("busy status", `FP_OFF_STATUS, 32'h0000_000F, 32'h0000_0001);
    wr(`FP_OFF_ADDR, 32'h0000_0040);
    rdc("addr held", `FP_OFF_ADDR, 32'h003F_FFFF, {10'h000, m_addr});
    wr(`FP_OFF_CTRL, 32'h0000_0002);
    wait_idle();
    rdc("abort status", `FP_OFF_STATUS, 32'h0000_0007, 32'h0000_0000);
    // Unmapped offset reads zero and ignores writes
    wr(8'h20, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    // Second reset in mid-poll
    wr(`FP_OFF_CTRL, 32'h0000_0001);
    repeat (30) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk("pins idle", 32'h0000_000E,
        {28'h0, flash_pins.ce_n, flash_pins.oe_n, flash_pins.we_n, flash_pins.dq_oe});
    @(posedge hclk);
    hresetn <= 1'b1;
    load(2'd0, 8'd1, 1'b0, 1'b0, 16'h0000, 16'h0000);
    rdc("addr reset", `FP_OFF_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("exp reset", `FP_OFF_EXP, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("ctrl reset", `FP_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("status reset", `FP_OFF_STATUS, 32'h0000_0037, 32'h0000_0000);
    summarize();
  end
endmodule // flash_write_status_reporting_tb

`default_nettype wire
